/* File: verilog/clock_source_irq.sv */
/*
 Clock-source interrupt controller: enable set/clear registers, sticky
 flags raised by status edges, and one level interrupt, behind APB.
 Assumes an APB master on pclk and status lines from other clock domains.
*/
// How it works
// RULE1: Writing zero to any enable bit through the set register leaves it as it was.
// RULE2: Writing one to bit 8 enables the FLL reference-clock-stopped interrupt.
// RULE3: Writing one to bit 7 enables the FLL coarse-lock interrupt.
// RULE4: Writing one to bit 6 enables the FLL fine-lock interrupt.
// RULE5: Writing one to bit 5 enables the FLL out-of-bounds interrupt.
// RULE6: Writing one to bit 4 enables the FLL ready interrupt.
// RULE7: Writing one to bit 3 enables the 8 MHz RC oscillator ready interrupt.
// RULE8: Writing one to bit 2 enables the 32 kHz RC oscillator ready interrupt.
// RULE9: Writing one to bit 1 enables the 32 kHz crystal ready interrupt.
// RULE10: Writing one to bit 0 enables the main crystal ready interrupt.
// RULE11: An enabled source whose flag is set raises the interrupt request.
// RULE12: A disabled source never contributes to the interrupt request.
// RULE13: Writing one to the clear register disables that source; zero does nothing.
// RULE14: A flag is set on a rising status bit whatever its enable.
// RULE15: A flag clears when one is written to it; zero does nothing.
// RULE16: Both enable registers read back the shared enable state.
`timescale 1ns/1ps
module clock_source_irq
   import clk_irq_pkg::*;
#(
   parameter int N = NUM_SRC
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [clk_irq_pkg::ADDR_W-1:0] paddr,
   input  wire logic [clk_irq_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [clk_irq_pkg::DATA_W-1:0] prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [N-1:0]              clock_status_in,
   output logic                           irq
);
   import clk_irq_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ACCESS = 2'b01
   } apb_state_t;

   apb_state_t       state_ff;
   apb_state_t       nxt_state;
   logic [N-1:0]     enable_ff;
   logic [N-1:0]     nxt_enable;
   logic [N-1:0]     flag_ff;
   logic [N-1:0]     nxt_flag;
   logic [31:0]      prdata_ff;
   logic             pready_ff;
   logic             pslverr_ff;
   logic             irq_ff;
   logic             setup_phase;
   logic             wr_take;
   logic [N-1:0]     wmask;
   logic [31:0]      rd_value;
   logic             rd_hit;

   // Named views of the enable word, one per source; the checks below look
   // at every enable bit under the name of its own source
   logic             fll_ref_clock_stopped_ie;
   logic             fll_coarse_lock_ie;
   logic             fll_fine_lock_ie;
   logic             fll_out_of_bounds_ie;
   logic             fll_ready_ie;
   logic             rc8m_ready_ie;
   logic             rc32k_ready_ie;
   logic             crystal32k_ready_ie;
   logic             crystal_main_ready_ie;

   // Plain taps of the enable flops, no extra state
   assign fll_ref_clock_stopped_ie = enable_ff[BIT_FLL_REFSTP];
   assign fll_coarse_lock_ie       = enable_ff[BIT_FLL_COARSE];
   assign fll_fine_lock_ie         = enable_ff[BIT_FLL_FINE];
   assign fll_out_of_bounds_ie     = enable_ff[BIT_FLL_OOB];
   assign fll_ready_ie             = enable_ff[BIT_FLL_RDY];
   assign rc8m_ready_ie            = enable_ff[BIT_RC8M];
   assign rc32k_ready_ie           = enable_ff[BIT_RC32K];
   assign crystal32k_ready_ie      = enable_ff[BIT_RC_X32K];
   assign crystal_main_ready_ie    = enable_ff[BIT_RC_MAIN];

   edge_event_if #(.N(N)) ev ();

   // Status lines cross into pclk and become rise pulses
   status_edge_detect #(.N(N)) u_edge (
      .pclk       (pclk),
      .presetn    (presetn),
      .raw_status (clock_status_in),
      .ev         (ev.src)
   );

   // Byte-lane gating of write data; bytes without pstrb write nothing
   function automatic logic [N-1:0] lane_data(input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return N'(d & m);
   endfunction : lane_data

   // Address decode shared by read mux and error answer
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction : addr_hit

   assign setup_phase = psel & ~penable;
   assign wr_take     = psel & penable & pready_ff & pwrite;
   assign wmask       = lane_data(pwdata, pstrb);

   // APB phase tracking: the answer comes in the first access cycle
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (setup_phase) begin
               nxt_state = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Read mux; unused high bits read as zero
   always_comb begin
      rd_value = 32'h0000_0000;
      rd_hit   = 1'b1;
      if (addr_hit(paddr, OFS_ENABLE_CLR) || addr_hit(paddr, OFS_ENABLE_SET)) begin
         rd_value = 32'(enable_ff); // RULE16
      end else if (addr_hit(paddr, OFS_FLAG)) begin
         rd_value = 32'(flag_ff);
      end else if (addr_hit(paddr, OFS_STATUS)) begin
         rd_value = 32'(ev.level);
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Answer is prepared in setup so every bus output comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= setup_phase && (state_ff == ST_IDLE);
         pslverr_ff <= setup_phase && !rd_hit;
         prdata_ff  <= (setup_phase && !pwrite) ? rd_value : 32'h0000_0000;
      end
   end

   // Enable state: set register ORs in ones, clear register removes them
   always_comb begin
      nxt_enable = enable_ff;
      if (wr_take && addr_hit(paddr, OFS_ENABLE_SET)) begin
         nxt_enable = enable_ff | wmask; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10
      end else if (wr_take && addr_hit(paddr, OFS_ENABLE_CLR)) begin
         nxt_enable = enable_ff & ~wmask; // RULE13
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_ff <= N'(ENABLE_RESET);
      end else begin
         enable_ff <= nxt_enable;
      end
   end

   // Sticky flags; a rise in the clearing cycle wins so no event is lost
   always_comb begin
      nxt_flag = flag_ff;
      if (wr_take && addr_hit(paddr, OFS_FLAG)) begin
         nxt_flag = flag_ff & ~wmask; // RULE15
      end
      nxt_flag = nxt_flag | ev.rise; // RULE14
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_ff <= N'(FLAG_RESET);
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // Level interrupt, one cycle behind the flag/enable pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(flag_ff & enable_ff); // RULE11 RULE12
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq     = irq_ff;

   // Checks beside the logic
   logic wr_set_c;
   logic wr_clr_c;
   logic wr_flag_c;
   logic rd_set_c;
   assign wr_set_c  = wr_take && addr_hit(paddr, OFS_ENABLE_SET);
   assign wr_clr_c  = wr_take && addr_hit(paddr, OFS_ENABLE_CLR);
   assign wr_flag_c = wr_take && addr_hit(paddr, OFS_FLAG);
   assign rd_set_c  = setup_phase && !pwrite && addr_hit(paddr, OFS_ENABLE_SET);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_set_keeps_zero: assert property ( // RULE1
      wr_set_c |=> enable_ff == ($past(enable_ff) | $past(wmask)))
      else $error("enable set write disturbed other bits");

   a_set_bits_on: assert property ( // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10
      wr_set_c |=> (enable_ff & $past(wmask)) == $past(wmask))
      else $error("enable bit not set by write of one");

   a_clr_bits_off: assert property ( // RULE13
      wr_clr_c |=> enable_ff == ($past(enable_ff) & ~$past(wmask)))
      else $error("enable clear write wrong");

   a_flag_on_rise: assert property ( // RULE14
      (ev.rise != '0) |=> (flag_ff & $past(ev.rise)) == $past(ev.rise))
      else $error("flag missed a status rise");

   a_flag_w1c: assert property ( // RULE15
      wr_flag_c && ev.rise == '0 |=> flag_ff == ($past(flag_ff) & ~$past(wmask)))
      else $error("flag clear write wrong");

   a_irq_raised: assert property ( // RULE11
      (|(flag_ff & enable_ff)) |=> irq)
      else $error("interrupt missing for enabled flag");

   a_irq_masked: assert property ( // RULE12
      !(|(flag_ff & enable_ff)) |=> !irq)
      else $error("interrupt from disabled source");

   a_read_enable: assert property ( // RULE16
      rd_set_c |=> pready && prdata == 32'($past(enable_ff)))
      else $error("enable readback wrong");

   a_answer_timing: assert property (
      setup_phase && state_ff == ST_IDLE |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");

   // One check per enable bit, each under the name of its source
   a_set_refstop: assert property ( // RULE2
      wr_set_c && wmask[BIT_FLL_REFSTP] |=> fll_ref_clock_stopped_ie)
      else $error("reference-stopped enable not set");

   a_set_coarse: assert property ( // RULE3
      wr_set_c && wmask[BIT_FLL_COARSE] |=> fll_coarse_lock_ie)
      else $error("coarse-lock enable not set");

   a_set_fine: assert property ( // RULE4
      wr_set_c && wmask[BIT_FLL_FINE] |=> fll_fine_lock_ie)
      else $error("fine-lock enable not set");

   a_set_oob: assert property ( // RULE5
      wr_set_c && wmask[BIT_FLL_OOB] |=> fll_out_of_bounds_ie)
      else $error("out-of-bounds enable not set");

   a_set_fll_ready: assert property ( // RULE6
      wr_set_c && wmask[BIT_FLL_RDY] |=> fll_ready_ie)
      else $error("fll ready enable not set");

   a_set_rc8m: assert property ( // RULE7
      wr_set_c && wmask[BIT_RC8M] |=> rc8m_ready_ie)
      else $error("8 MHz oscillator enable not set");

   a_set_rc32k: assert property ( // RULE8
      wr_set_c && wmask[BIT_RC32K] |=> rc32k_ready_ie)
      else $error("32 kHz oscillator enable not set");

   a_set_xtal32k: assert property ( // RULE9
      wr_set_c && wmask[BIT_RC_X32K] |=> crystal32k_ready_ie)
      else $error("32 kHz crystal enable not set");

   a_set_xtal_main: assert property ( // RULE10
      wr_set_c && wmask[BIT_RC_MAIN] |=> crystal_main_ready_ie)
      else $error("main crystal enable not set");

   // Nothing moves without its own write or status event
   a_enable_hold: assert property ( // RULE1 RULE13
      !wr_set_c && !wr_clr_c |=> enable_ff == $past(enable_ff))
      else $error("enable changed without a write");

   a_flag_hold: assert property ( // RULE14 RULE15
      !wr_flag_c && ev.rise == '0 |=> flag_ff == $past(flag_ff))
      else $error("flag changed without a write or rise");

   // Answer shape: one-cycle pready, error and data only alongside it
   a_pready_pulse: assert property (
      pready |=> !pready)
      else $error("pready held longer than one cycle");

   a_err_unmapped: assert property (
      setup_phase && state_ff == ST_IDLE && !rd_hit |=> pready && pslverr)
      else $error("unmapped address not refused");

   a_err_with_ready: assert property (
      pslverr |-> pready)
      else $error("error answer without pready");

   a_rdata_quiet: assert property (
      !pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer cycle");

   a_read_flag: assert property (
      setup_phase && state_ff == ST_IDLE && !pwrite && addr_hit(paddr, OFS_FLAG)
      |=> prdata == 32'($past(flag_ff)))
      else $error("flag readback wrong");

   c_set_write: cover property (wr_set_c ##1 enable_ff != '0);
   c_irq_fire:  cover property (ev.rise != '0 ##[1:4] irq);
   c_clr_race:  cover property (wr_flag_c && ev.rise != '0);
   c_bad_addr:  cover property (pslverr);
   c_part_lane: cover property (wr_take && pstrb != 4'hF);

endmodule : clock_source_irq

/* File: verilog/clk_irq_pkg.sv */
/*
 Constants for the clock-source interrupt block: register offsets, field
 positions, reset values and bus timing.
 Assumes a 32-bit APB bus with byte addresses and one word per register.
*/
package clk_irq_pkg;

   // Bus geometry and source count
   localparam int          ADDR_W         = 12;
   localparam int          DATA_W         = 32;
   localparam int          NUM_SRC        = 9;

   // Register byte offsets
   localparam logic [11:0] OFS_ENABLE_CLR = 12'h000;
   localparam logic [11:0] OFS_ENABLE_SET = 12'h004;
   localparam logic [11:0] OFS_FLAG       = 12'h008;
   localparam logic [11:0] OFS_STATUS     = 12'h00C;

   // Field positions inside the enable, flag and status words
   localparam int          BIT_RC_MAIN    = 0;
   localparam int          BIT_RC_X32K    = 1;
   localparam int          BIT_RC32K      = 2;
   localparam int          BIT_RC8M       = 3;
   localparam int          BIT_FLL_RDY    = 4;
   localparam int          BIT_FLL_OOB    = 5;
   localparam int          BIT_FLL_FINE   = 6;
   localparam int          BIT_FLL_COARSE = 7;
   localparam int          BIT_FLL_REFSTP = 8;

   // Values after reset
   localparam logic [8:0]  ENABLE_RESET   = 9'h000;
   localparam logic [8:0]  FLAG_RESET     = 9'h000;
   localparam logic [8:0]  SYNC_RESET     = 9'h000;

   // Cycles from setup phase to pready
   localparam int          APB_WAIT_CYC   = 1;

endpackage : clk_irq_pkg

/* File: verilog/edge_event_if.sv */
/*
 Carrier between the status synchroniser and the register block.
 Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface edge_event_if #(
   parameter int N = 9
);
   logic [N-1:0] level;   // Filtered status level
   logic [N-1:0] rise;    // One-cycle pulse on a filtered 0 to 1 change

   modport src (output level, output rise);
   modport dst (input  level, input  rise);
endinterface : edge_event_if

/* File: verilog/status_edge_detect.sv */
/*
 Three-stage synchroniser and rising-edge detector for the oscillator and
 FLL status lines.
 Assumes raw_status comes from other clock domains; pclk is free running.
*/
`timescale 1ns/1ps
module status_edge_detect
   import clk_irq_pkg::*;
#(
   parameter int N = NUM_SRC
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [N-1:0] raw_status,
   edge_event_if.src         ev
);
   logic [N-1:0] meta_ff;
   logic [N-1:0] sync2_ff;
   logic [N-1:0] sync3_ff;
   logic [N-1:0] level_ff;
   logic [N-1:0] rise_ff;
   logic [N-1:0] nxt_level;

   // Synchroniser chain; meta_ff feeds sync2_ff only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff  <= N'(SYNC_RESET);
         sync2_ff <= N'(SYNC_RESET);
         sync3_ff <= N'(SYNC_RESET);
      end else begin
         meta_ff  <= raw_status;
         sync2_ff <= meta_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // A change counts only once two stages agree, filtering single glitches
   always_comb begin
      for (int i = 0; i < N; i++) begin
         nxt_level[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : level_ff[i];
      end
   end

   // Level and rising-edge pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_ff <= N'(SYNC_RESET);
         rise_ff  <= N'(SYNC_RESET);
      end else begin
         level_ff <= nxt_level;
         rise_ff  <= nxt_level & ~level_ff; // RULE14
      end
   end

   assign ev.level = level_ff;
   assign ev.rise  = rise_ff;

endmodule : status_edge_detect

/* File: tb/clock_source_irq_tb.sv */
/*
 Self-checking bench for the clock-source interrupt block: APB register
 traffic, status edges, sticky flags and the level interrupt.
 Assumes the clk_irq_pkg constants and a single 100 MHz pclk domain.
*/
`timescale 1ns/1ps
module clock_source_irq_tb;
   import clk_irq_pkg::*;
   logic                pclk = 1'b0;
   logic                presetn = 1'b0;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic [ADDR_W-1:0]   paddr = '0;
   logic [DATA_W-1:0]   pwdata = '0;
   logic [3:0]          pstrb = 4'hF;
   logic [DATA_W-1:0]   prdata;
   logic                pready;
   logic                pslverr;
   logic [NUM_SRC-1:0]  clock_status_in = '0;
   logic                irq;
   logic [8:0]          en_m = ENABLE_RESET;
   logic [8:0]          fl_m = FLAG_RESET;
   logic [8:0]          st_m = SYNC_RESET;
   logic [31:0]         rd;
   logic                er;
   integer              seed = 32'h400be1af;
   int                  miscompares = 0;
   int                  num_checks = 0;

   clock_source_irq clock_source_irq_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clock_status_in(clock_status_in), .irq(irq));

   // 100 MHz clock
   always #5 pclk = ~pclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // One APB transfer; the request is held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0, 32'h1, "pready timeout");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Register write that also advances the bench model
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [8:0] m;
      apb(1'b1, a, d);
      // Lane 0 gates bits 7:0, lane 1 bit 8; strobes stood through the transfer
      m = d[8:0] & {pstrb[1], {8{pstrb[0]}}};
      if (a == OFS_ENABLE_SET) en_m = en_m | m;
      if (a == OFS_ENABLE_CLR) en_m = en_m & ~m;
      if (a == OFS_FLAG) fl_m = fl_m & ~m;
      chk({31'h0, er}, 32'h0, "write error");
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, "read data");
      chk({31'h0, er}, {31'h0, exp_err}, "read error");
   endtask : rd_chk

   // Irq follows flag and enable a cycle late, so let two edges pass
   task automatic irq_chk();
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, {31'h0, |(fl_m & en_m)}, "irq level");
   endtask : irq_chk

   // New status levels; a rising bit raises its flag once synchronised
   task automatic set_status(input logic [8:0] v);
      @(posedge pclk);
      clock_status_in <= v;
      fl_m = fl_m | (v & ~st_m);
      st_m = v;
      repeat (8) @(posedge pclk);
   endtask : set_status

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   // Whole run is under a thousand cycles
   initial begin
      #200000;
      miscompares++;
      final_report();
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(OFS_ENABLE_SET, 32'h0, 1'b0);
      rd_chk(OFS_FLAG, 32'h0, 1'b0);
      $display("test reset done");
      // Walk a single one with upper garbage; earlier enables must survive
      for (int i = 0; i < 9; i++) begin
         wr(OFS_ENABLE_SET, 32'hFFFFFE00 | (32'h1 << i));
         rd_chk(OFS_ENABLE_SET, {23'h0, en_m}, 1'b0);
         rd_chk(OFS_ENABLE_CLR, {23'h0, en_m}, 1'b0);
      end
      $display("test enable set done");
      // Random set and clear mixes against the model
      for (int i = 0; i < 20; i++) begin
         wr((i % 2) ? OFS_ENABLE_SET : OFS_ENABLE_CLR, $random(seed));
         rd_chk(OFS_ENABLE_SET, {23'h0, en_m}, 1'b0);
      end
      $display("test enable clear done");
      // Status edges, masking and write-one-to-clear of flags
      for (int i = 0; i < 16; i++) begin
         set_status($random(seed));
         rd_chk(OFS_FLAG, {23'h0, fl_m}, 1'b0);
         rd_chk(OFS_STATUS, {23'h0, st_m}, 1'b0);
         irq_chk();
         wr((i % 2) ? OFS_ENABLE_SET : OFS_ENABLE_CLR, $random(seed));
         irq_chk();
         wr(OFS_FLAG, $random(seed));
         rd_chk(OFS_FLAG, {23'h0, fl_m}, 1'b0);
         irq_chk();
      end
      $display("test flags and irq done");
      // Strobes gate lanes: lane 1 carries bit 8, lane 0 bits 7:0
      wr(OFS_ENABLE_SET, 32'h000001FF);
      pstrb <= 4'h2;
      wr(OFS_ENABLE_CLR, 32'h000001FF);
      rd_chk(OFS_ENABLE_SET, {23'h0, en_m}, 1'b0);
      pstrb <= 4'h1;
      wr(OFS_ENABLE_CLR, 32'h000001FF);
      rd_chk(OFS_ENABLE_CLR, {23'h0, en_m}, 1'b0);
      pstrb <= 4'h2;
      wr(OFS_ENABLE_SET, 32'h000001FF);
      rd_chk(OFS_ENABLE_SET, {23'h0, en_m}, 1'b0);
      pstrb <= 4'hF;
      $display("test strobes done");
      // A rise landing in the cycle of its clearing write must keep the flag
      set_status(9'h000);
      wr(OFS_FLAG, 32'h000001FF);
      @(posedge pclk);
      clock_status_in <= 9'h1FF;
      st_m = 9'h1FF;
      // Raw change seen at the next edge; its rise pulse meets the write at the fifth
      repeat (2) @(posedge pclk);
      apb(1'b1, OFS_FLAG, 32'h000001FF);
      fl_m = 9'h1FF;
      chk({31'h0, er}, 32'h0, "race write error");
      rd_chk(OFS_FLAG, {23'h0, fl_m}, 1'b0);
      irq_chk();
      $display("test clear race done");
      // Reset in mid-run with status lines high: all clear, then flags return
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0, "irq in reset");
      presetn <= 1'b1;
      en_m = ENABLE_RESET;
      fl_m = FLAG_RESET;
      rd_chk(OFS_ENABLE_SET, {23'h0, en_m}, 1'b0);
      repeat (8) @(posedge pclk);
      fl_m = st_m;
      rd_chk(OFS_FLAG, {23'h0, fl_m}, 1'b0);
      irq_chk();
      wr(OFS_ENABLE_SET, 32'h000001FF);
      irq_chk();
      $display("test mid-run reset done");
      // Unmapped place refuses; status register ignores writes
      apb(1'b1, 12'h010, 32'hFFFFFFFF);
      chk({31'h0, er}, 32'h1, "unmapped write error");
      rd_chk(12'hFFC, 32'h0, 1'b1);
      rd_chk(OFS_FLAG, {23'h0, fl_m}, 1'b0);
      apb(1'b1, OFS_STATUS, 32'h000001FF);
      chk({31'h0, er}, 32'h0, "status write error");
      rd_chk(OFS_STATUS, {23'h0, st_m}, 1'b0);
      rd_chk(OFS_ENABLE_SET, {23'h0, en_m}, 1'b0);
      $display("test refusal done");
      final_report();
   end
endmodule : clock_source_irq_tb
